// ==== host_port_device.sv ====
// device end: pin function selection for the 8-bit host port
// assumes the control and direction settings come from core logic on core_clk
`timescale 1ns/10ps
module host_port_device
  import pin_select_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT
)(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  host_port_if.device                port,
  input  wire logic [CTL_WIDTH-1:0]  port_ctl,
  input  wire logic [WIDTH-1:0]      gpio_dir,
  input  wire logic [WIDTH-1:0]      gpio_out,
  input  wire logic                  stop_mode,
  input  wire logic [DATA_WIDTH-1:0] read_data,
  output logic      [WIDTH-1:0]      gpio_in,
  output logic                       host_sel,
  output logic      [10:0]           host_addr,
  output logic                       host_rd,
  output logic                       host_wr,
  output logic      [DATA_WIDTH-1:0] write_data
);

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  logic [CTL_WIDTH-1:0] ctl_q;
  pin_func_t            func;
  wire logic            dual_ds = ctl_q[CTL_DUAL_DS_BIT];
  wire logic            as_pol  = ctl_q[CTL_AS_POL_BIT];
  wire logic            cs_pol  = ctl_q[CTL_CS_POL_BIT];
  wire logic            ds_pol  = ctl_q[CTL_DS_POL_BIT];

  // control register; reset value selects gpio, with pin directions then taken from gpio_dir
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctl_q <= CTL_RESET; // R14
    else
      ctl_q <= port_ctl; // R01
  end

  // host and gpio exclusive; one function for every pin
  assign func = pin_func_t'(!ctl_q[CTL_HOST_EN_BIT] ? FUNC_GPIO :
                (ctl_q[CTL_MUXED_BIT] ? FUNC_HOST_MUXED : FUNC_HOST_PLAIN)); // R13

  // ----------------------------------------------------------------
  // input synchroniser and stop-state freeze
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] sync1_q;
  logic [WIDTH-1:0] pin_q;
  logic [WIDTH-1:0] held_q;
  logic [WIDTH-1:0] in_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      pin_q   <= '0;
    end
    else
    begin
      sync1_q <= port.pin_level;
      pin_q   <= sync1_q;
    end
  end

  // inputs are frozen (ignored) in stop and during reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      in_q <= '0; // R14
    else if (!stop_mode)
      in_q <= pin_q; // R12
  end

  // ----------------------------------------------------------------
  // host strobe decode
  // ----------------------------------------------------------------
  wire logic as_act  = (in_q[PIN_SEL0_AS] == as_pol); // R07
  wire logic cs_act  = (in_q[PIN_CS_A10] == cs_pol); // R08
  wire logic rd_act  = (in_q[PIN_RW_RD] == ds_pol); // R10
  wire logic ds_act  = (in_q[PIN_DS_WR] == ds_pol); // R11
  wire logic muxed   = (func == FUNC_HOST_MUXED);
  wire logic plain   = (func == FUNC_HOST_PLAIN);
  wire logic sel_act = plain ? cs_act : muxed; // R08
  wire logic rd_now  = sel_act && (dual_ds ? rd_act : (ds_act && in_q[PIN_RW_RD])); // R09 R10
  wire logic wr_now  = sel_act && ds_act && (dual_ds || !in_q[PIN_RW_RD]); // R11

  logic [10:0] addr_q;
  logic        as_prev_q;

  // muxed address latched on the strobe's leading edge; plain address is direct
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      addr_q    <= '0;
      as_prev_q <= 1'b0;
    end
    else
    begin
      as_prev_q <= as_act;
      if (muxed && as_act && !as_prev_q)
        addr_q <= {in_q[PIN_CS_A10], in_q[PIN_SEL2_A9], in_q[PIN_SEL1_A8], in_q[7:0]}; // R03 R06 R07
      else if (plain)
        addr_q <= {8'h00, in_q[PIN_SEL2_A9], in_q[PIN_SEL1_A8], in_q[PIN_SEL0_AS]}; // R05
    end
  end

  // ----------------------------------------------------------------
  // user-side outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      host_sel   <= 1'b0;
      host_addr  <= '0;
      host_rd    <= 1'b0;
      host_wr    <= 1'b0;
      write_data <= '0;
      gpio_in    <= '0;
    end
    else
    begin
      host_sel   <= sel_act && !stop_mode;
      host_addr  <= addr_q;
      host_rd    <= rd_now && !stop_mode;
      host_wr    <= wr_now && !stop_mode;
      write_data <= in_q[7:0]; // R02 R03
      gpio_in    <= (func == FUNC_GPIO) ? in_q : '0;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, last level held while stopped
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] out_d;
  logic [WIDTH-1:0] oe_d;
  logic [WIDTH-1:0] oe_q;

  always_comb
  begin
    out_d = '0;
    oe_d  = '0;
    unique case (func)
      FUNC_GPIO:
      begin
        out_d = gpio_out;
        oe_d  = gpio_dir; // R04
      end
      FUNC_HOST_PLAIN, FUNC_HOST_MUXED:
      begin
        out_d[7:0] = read_data;
        oe_d[7:0]  = {DATA_WIDTH{rd_now}}; // R02 R03
      end
    endcase
  end

  // outputs and enables freeze in stop, so driven pins keep their level
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      held_q <= '0;
      oe_q   <= '0; // R14
    end
    else if (!stop_mode)
    begin
      held_q <= out_d;
      oe_q   <= oe_d; // R12
    end
  end

  assign port.dev_out = held_q;
  assign port.dev_oe  = oe_q;

endmodule

// ==== pin_select_pkg.sv ====
// constants and types shared by both ends of the host port pin function select
// assumes one core clock, asynchronous active-high reset, pins resolved by the interface
//
// Function
// R01: pin functions follow the 16-bit port control setting
// R02: non-muxed host bus: eight pins are data 0-7
// R03: muxed host bus: eight pins carry address/data 0-7
// R04: gpio mode: direction per pin from direction setting
// R05: host drives register select bits 0-2 non-muxed
// R06: host drives address bits 8-10 in muxed mode
// R07: address strobe latches address, programmable polarity, low default
// R08: respond only with chip select active, low default
// R09: host gives direction on read/write select input
// R10: double strobe: read strobe, programmable polarity, low default
// R11: data or write strobe, programmable polarity, low default
// R12: stop state: inputs ignored, outputs keep last level
// R13: each pin one function; host and gpio exclusive
// R14: during reset all pins ignored inputs, none driven
package pin_select_pkg;

  // ----------------------------------------------------------------
  // port control field positions
  // ----------------------------------------------------------------
  localparam int CTL_WIDTH       = 16;
  localparam int CTL_HOST_EN_BIT = 0;   // 1 host function, 0 gpio
  localparam int CTL_MUXED_BIT   = 1;   // 1 multiplexed address/data bus
  localparam int CTL_DUAL_DS_BIT = 2;   // 1 double data strobe
  localparam int CTL_AS_POL_BIT  = 3;   // 1 address strobe active high
  localparam int CTL_CS_POL_BIT  = 4;   // 1 chip select active high
  localparam int CTL_DS_POL_BIT  = 5;   // 1 data / read / write strobes active high

  // ----------------------------------------------------------------
  // reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] CTL_RESET   = 16'h0000;
  localparam int          PIN_COUNT   = 16;
  localparam int          DATA_WIDTH  = 8;
  localparam int          SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // pin positions of the upper group
  // ----------------------------------------------------------------
  localparam int PIN_SEL0_AS   = 8;   // reg select 0 / address strobe
  localparam int PIN_SEL1_A8   = 9;   // reg select 1 / address 8
  localparam int PIN_SEL2_A9   = 10;  // reg select 2 / address 9
  localparam int PIN_RW_RD     = 11;  // read/write select / read strobe
  localparam int PIN_DS_WR     = 12;  // data strobe / write strobe
  localparam int PIN_CS_A10    = 13;  // chip select / address 10

  typedef enum logic [1:0] {FUNC_GPIO, FUNC_HOST_PLAIN, FUNC_HOST_MUXED} pin_func_t;

endpackage

// ==== host_port_if.sv ====
// interface carrying the sixteen shared port pins between device and host ends
// assumes each end drives a pin only with its enable high; undriven pins are pulled up and read as 1
`timescale 1ns/10ps
interface host_port_if;
  import pin_select_pkg::*;

  logic [PIN_COUNT-1:0] dev_out;
  logic [PIN_COUNT-1:0] dev_oe;
  logic [PIN_COUNT-1:0] host_out;
  logic [PIN_COUNT-1:0] host_oe;
  logic [PIN_COUNT-1:0] pin_level;

  // wired resolution; the device wins a contended pin, a released pin floats high
  // so that the active-low strobes and chip select read idle between cycles
  assign pin_level = (dev_oe & dev_out) | (~dev_oe & host_oe & host_out) | ~(dev_oe | host_oe);

  modport device (output dev_out, output dev_oe, input pin_level);
  modport host   (output host_out, output host_oe, input pin_level);
endinterface

// ==== host_port_master.sv ====
// host end: drives the external bus cycles the device end decodes
// assumes the user side holds a request until done pulses
`timescale 1ns/10ps
module host_port_master
  import pin_select_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  host_port_if.host                  port,
  input  wire logic                  muxed,
  input  wire logic                  dual_ds,
  input  wire logic                  req,
  input  wire logic                  req_write,
  input  wire logic [10:0]           req_addr,
  input  wire logic [DATA_WIDTH-1:0] req_data,
  output logic                       done,
  output logic      [DATA_WIDTH-1:0] rd_data
);

  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_SETUP, S_STROBE, S_DONE} state_t;
  state_t           state_q;
  logic [3:0]       cnt_q;
  logic [PIN_COUNT-1:0] out_q;
  logic [PIN_COUNT-1:0] oe_q;
  logic [DATA_WIDTH-1:0] sync1_q;
  logic [DATA_WIDTH-1:0] sync2_q;

  // ----------------------------------------------------------------
  // bus cycle sequencer; strobes are active low (reset polarity)
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      cnt_q   <= '0;
      out_q   <= 16'hFFFF;
      oe_q    <= '0;
      done    <= 1'b0;
      rd_data <= '0;
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= port.pin_level[7:0];
      sync2_q <= sync1_q;
      done    <= 1'b0;
      cnt_q   <= cnt_q + 4'h1;
      unique case (state_q)
        S_IDLE:
        begin
          oe_q <= '0;
          // a high done means the answered request is still being withdrawn
          if (req && !done)
          begin
            cnt_q <= '0;
            oe_q  <= 16'h3F00;
            out_q <= 16'hFFFF;
            if (muxed)
            begin
              out_q[7:0] <= req_addr[7:0]; // R03
              oe_q[7:0]  <= 8'hFF;
              out_q[PIN_SEL0_AS] <= 1'b0; // R07
              out_q[PIN_SEL1_A8] <= req_addr[8]; // R06
              out_q[PIN_SEL2_A9] <= req_addr[9];
              out_q[PIN_CS_A10]  <= req_addr[10];
              state_q <= S_ADDR;
            end
            else
            begin
              out_q[PIN_SEL0_AS] <= req_addr[0]; // R05
              out_q[PIN_SEL1_A8] <= req_addr[1];
              out_q[PIN_SEL2_A9] <= req_addr[2];
              out_q[PIN_CS_A10]  <= 1'b0; // R08
              state_q <= S_SETUP;
            end
          end
        end
        S_ADDR:
          if (cnt_q == 4'h4)
          begin
            out_q[PIN_SEL0_AS] <= 1'b1;
            state_q <= S_SETUP;
          end
        S_SETUP:
        begin
          cnt_q <= '0;
          out_q[7:0] <= req_data; // R02
          oe_q[7:0]  <= {DATA_WIDTH{req_write}};
          out_q[PIN_RW_RD] <= dual_ds ? req_write : !req_write; // R09
          out_q[PIN_DS_WR] <= dual_ds ? !req_write : 1'b0; // R11
          if (dual_ds && !req_write)
            out_q[PIN_RW_RD] <= 1'b0; // R10
          state_q <= S_STROBE;
        end
        S_STROBE:
          if (cnt_q == 4'h8)
          begin
            rd_data <= sync2_q;
            out_q[PIN_RW_RD] <= dual_ds ? 1'b1 : out_q[PIN_RW_RD];
            out_q[PIN_DS_WR] <= 1'b1;
            state_q <= S_DONE;
          end
        S_DONE:
        begin
          out_q[PIN_CS_A10] <= 1'b1;
          oe_q    <= '0;
          done    <= 1'b1;
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign port.host_out = out_q;
  assign port.host_oe  = oe_q;

endmodule

// ==== host_port_pin_function_select_properties.sv ====
// checker for the pin function select, watching the shared pins and the device user side
// assumes default strobe polarities; instantiated beside the interface by the bench
`timescale 1ns/10ps
module host_port_pin_function_select_properties
  import pin_select_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic [PIN_COUNT-1:0]  dev_out,
  input wire logic [PIN_COUNT-1:0]  dev_oe,
  input wire logic [PIN_COUNT-1:0]  host_oe,
  input wire logic [PIN_COUNT-1:0]  pin_level,
  input wire logic [CTL_WIDTH-1:0]  port_ctl,
  input wire logic [PIN_COUNT-1:0]  gpio_dir,
  input wire logic [PIN_COUNT-1:0]  gpio_out,
  input wire logic                  stop_mode,
  input wire logic                  host_rd,
  input wire logic                  host_wr,
  input wire logic [DATA_WIDTH-1:0] read_data
);
  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence host_held;
    port_ctl[CTL_HOST_EN_BIT] [*3];
  endsequence
  sequence gpio_settled;
    (!port_ctl[CTL_HOST_EN_BIT] && !stop_mode && $stable(gpio_dir) && $stable(gpio_out)) [*4];
  endsequence
  sequence frozen;
    stop_mode [*3];
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_RESET_IDLE: assert property ($fell(rst) |-> dev_oe == '0 && host_oe == '0)
    else $error("pins driven at reset release");
  AST_HOST_UPPER_IN: assert property (host_held |-> dev_oe[13:8] == 6'h00)
    else $error("device drives a host control pin");
  AST_GPIO_DIR: assert property (gpio_settled
    |-> dev_oe == gpio_dir && (dev_out & gpio_dir) == (gpio_out & gpio_dir))
    else $error("gpio direction or level wrong");
  AST_STOP_HOLD: assert property (frozen |-> $stable(dev_oe) && $stable(dev_out))
    else $error("pins changed while stopped");
  AST_WR_STROBE: assert property (host_wr |-> $past(pin_level[PIN_DS_WR], 4) == 1'b0)
    else $error("write seen without strobe");
  AST_RD_STROBE: assert property (host_rd && port_ctl[CTL_DUAL_DS_BIT]
    |-> $past(pin_level[PIN_RW_RD], 4) == 1'b0)
    else $error("read seen without read strobe");
  AST_RW_DIR: assert property (host_rd && !port_ctl[CTL_DUAL_DS_BIT]
    |-> $past(pin_level[PIN_RW_RD], 4) && !$past(pin_level[PIN_DS_WR], 4))
    else $error("single strobe read without read select");
  AST_CS_GATE: assert property ((host_wr || host_rd) && port_ctl[1:0] == 2'h1
    |-> $past(pin_level[PIN_CS_A10], 4) == port_ctl[CTL_CS_POL_BIT])
    else $error("access taken without chip select");
  AST_READ_DRIVE: assert property ((host_held ##0 (dev_oe[7:0] != 8'h00))
    |-> dev_oe[7:0] == 8'hFF && dev_out[7:0] == read_data)
    else $error("data pins driven wrongly");
endmodule

// ==== host_port_pin_function_select_tb.sv ====
// testbench joining device and host ends through the port interface
// assumes default strobe polarities on the host end
`timescale 1ns/10ps
module host_port_pin_function_select_tb;
  import pin_select_pkg::*;
  typedef struct packed {logic mx; logic dl; logic wr; logic [10:0] addr; logic [7:0] data;} row_t;
  logic                  core_clk = 1'h0;
  logic                  rst = 1'h1;
  logic [CTL_WIDTH-1:0]  port_ctl = 16'h0000;
  logic [PIN_COUNT-1:0]  gpio_dir = 16'h0000;
  logic [PIN_COUNT-1:0]  gpio_out = 16'h0000;
  logic                  stop_mode = 1'h0;
  logic [7:0]            read_data = 8'h00;
  logic                  req = 1'h0;
  logic                  req_write = 1'h0;
  logic [10:0]           req_addr = 11'h000;
  logic [7:0]            req_data = 8'h00;
  logic                  muxed = 1'h0;
  logic                  dual_ds = 1'h0;
  logic [PIN_COUNT-1:0]  gpio_in;
  logic                  host_sel, host_rd, host_wr, done, cap_sel, cap_seen;
  logic [10:0]           host_addr, cap_addr;
  logic [7:0]            write_data, rd_data, cap_data;
  int                    err_total = 0;
  int                    n_compared = 0;
  int                    cycles = 0;
  row_t rows [8] = '{'{1'h0, 1'h0, 1'h1, 11'h005, 8'hA5}, '{1'h0, 1'h0, 1'h0, 11'h003, 8'h5A},
                     '{1'h0, 1'h1, 1'h1, 11'h006, 8'h3C}, '{1'h0, 1'h1, 1'h0, 11'h001, 8'hC3},
                     '{1'h1, 1'h0, 1'h1, 11'h7FF, 8'hFF}, '{1'h1, 1'h0, 1'h0, 11'h400, 8'h00},
                     '{1'h1, 1'h1, 1'h1, 11'h2AA, 8'h00}, '{1'h1, 1'h1, 1'h0, 11'h155, 8'h81}};
  logic [31:0] gp [3] = '{32'hFFFF_A5C3, 32'h00FF_1234, 32'h0000_FFFF};
  host_port_if hp_if();
  host_port_device host_port_device_i (.core_clk(core_clk), .rst(rst), .port(hp_if), .port_ctl(port_ctl),
    .gpio_dir(gpio_dir), .gpio_out(gpio_out), .stop_mode(stop_mode), .read_data(read_data), .gpio_in(gpio_in),
    .host_sel(host_sel), .host_addr(host_addr), .host_rd(host_rd), .host_wr(host_wr), .write_data(write_data));
  host_port_master host_port_master_i (.core_clk(core_clk), .rst(rst), .port(hp_if), .muxed(muxed),
    .dual_ds(dual_ds), .req(req), .req_write(req_write), .req_addr(req_addr), .req_data(req_data),
    .done(done), .rd_data(rd_data));
  host_port_pin_function_select_properties props_i (.core_clk(core_clk), .rst(rst), .dev_out(hp_if.dev_out),
    .dev_oe(hp_if.dev_oe), .host_oe(hp_if.host_oe), .pin_level(hp_if.pin_level), .port_ctl(port_ctl),
    .gpio_dir(gpio_dir), .gpio_out(gpio_out), .stop_mode(stop_mode), .host_rd(host_rd), .host_wr(host_wr),
    .read_data(read_data));
  // ----------------------------------------------------------------
  // clock, capture and timeout
  // ----------------------------------------------------------------
  always #25 core_clk = ~core_clk;
  // keep what the device presented while a strobe was seen
  always @(posedge core_clk)
  begin
    if (host_wr === 1'h1 || host_rd === 1'h1)
    begin
      cap_addr <= host_addr;
      cap_data <= write_data;
      cap_sel  <= host_sel;
      cap_seen <= 1'h1;
    end
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one host bus cycle; req is held until done is seen, then dropped at that edge
  task automatic host_cycle(input row_t r);
    int k;
    k = 0;
    cap_seen = 1'h0;
    @(posedge core_clk);
    muxed <= r.mx;
    dual_ds <= r.dl;
    req_write <= r.wr;
    req_addr <= r.addr;
    req_data <= r.data;
    read_data <= r.data;
    req <= 1'h1;
    @(posedge core_clk);
    while (done !== 1'h1 && k < 40)
    begin
      @(posedge core_clk);
      k++;
    end
    req <= 1'h0;
    check(16'(k < 40), 16'h0001, "done");
    wait_n(6);
  endtask
  task automatic reset_check();
    check(hp_if.dev_oe | hp_if.host_oe, 16'h0000, "pins driven in reset");
    check({host_rd, host_wr, gpio_in[13:0]}, 16'h0000, "outputs in reset");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    wait_n(2);
    reset_check();
    rst <= 1'h0;
    foreach (gp[i])
    begin
      @(posedge core_clk);
      gpio_dir <= gp[i][31:16];
      gpio_out <= gp[i][15:0];
      wait_n(6);
      check(hp_if.dev_oe, gp[i][31:16], "gpio direction");
      check(gpio_in, (gp[i][15:0] & gp[i][31:16]) | ~gp[i][31:16], "gpio level");
    end
    // stop state keeps the last output levels, checked on dev_out while gpio_dir leaves every pin undriven
    stop_mode <= 1'h1;
    wait_n(3);
    gpio_out <= 16'hF00F;
    wait_n(6);
    check(hp_if.dev_out, 16'hFFFF, "held in stop");
    stop_mode <= 1'h0;
    gpio_dir <= 16'h0000;
    foreach (rows[i])
    begin
      port_ctl <= {13'h0000, rows[i].dl, rows[i].mx, 1'h1};
      wait_n(4);
      host_cycle(rows[i]);
      check(16'(cap_seen), 16'h0001, "strobe seen");
      if (rows[i].wr)
        check(16'(cap_data), 16'(rows[i].data), "write data");
      else
        check(16'(rd_data), 16'(rows[i].data), "read data");
      if (rows[i].mx)
        check(16'(cap_addr), 16'(rows[i].addr), "muxed address");
      else
        check(16'({cap_sel, cap_addr[2:0]}), 16'({1'h1, rows[i].addr[2:0]}), "select");
    end
    // chip select made active high: the low select of the host is refused
    port_ctl <= 16'h0011;
    wait_n(4);
    host_cycle(rows[0]);
    check(16'(cap_seen), 16'h0000, "refused access");
    rst <= 1'h1;
    wait_n(2);
    reset_check();
    rst <= 1'h0;
    wait_n(2);
    wrap_up();
  end
endmodule
